// ---- src/pin_mux_defs.svh ----
// constants for the port pin function mux
// assumes inclusion by pin_mux_pkg.sv and the mux module
//
// Operation
// - pin 2.7 resets to crystal output, select set; clear it for input use
// - other covered port 3 and 4 pins reset to plain I/O, select clear
// - serial unit functions take pin direction from the serial unit
// - serial0 clock beats serial1 slave enable; serial1 forced to 3-wire
// - serial1 clock beats serial0 slave enable; serial0 forced to 3-wire
// - low analog enable bit kills output driver and Schmitt input
// - high analog enable bit kills port 4 driver and Schmitt input
// - route 11 with function not 000 ties adc 12/13 to opamps, cuts pads
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
`define P2_SEL_RESET 1'b1
`define P3_SEL_RESET 8'h00
`define P4_SEL_RESET 5'h00
`define DIR_RESET_8 8'h00
`define DIR_RESET_5 5'h00
`define OA_ROUTE_INTERNAL 2'h3
`define OA_FUNC_OFF 3'h0
// analog enable bit positions
`define AE_LO_P30 5
`define AE_LO_P36 6
`define AE_LO_P37 7
`define AE_HI_P43 4
`define AE_HI_P44 5
// port 3 pin positions
`define P3_S1STE_S0CLK 0
`define P3_S1CLK_S0STE 3
`define P3_ANALOG_6 6
`define P3_ANALOG_7 7
`define P3_SERIAL_LAST 5
`define P3_PINS 8
// port 4 pin positions
`define P4_ANALOG_3 3
`define P4_ANALOG_4 4
`define P4_PINS 5
// register image reset values
`define PIN_LOW 1'b0
`define OUT_RESET_8 8'h00
`define OUT_RESET_5 5'h00
`define IE_RESET_8 8'hff
`define IE_RESET_5 5'h1f
`define OA_INT_RESET 2'h0
`endif

// ---- src/pin_mux_pkg.sv ----
// types for the port pin function mux
// assumes pin_mux_defs.svh on the include path
`include "pin_mux_defs.svh"
package pin_mux_pkg;
  typedef struct packed {
    logic p27_out;
    logic p27_oe;
    logic [7:0] p3_out;
    logic [7:0] p3_oe;
    logic [7:0] p3_ie;
    logic [4:0] p4_out;
    logic [4:0] p4_oe;
    logic [4:0] p4_ie;
    logic [7:0] p3_in;
    logic [4:0] p4_in;
    logic p27_in;
    logic s0_three_wire;
    logic s1_three_wire;
    logic [1:0] opamp_internal;
  } mux_state_t;
endpackage

// ---- src/port_pin_function_mux.sv ----
// pin function mux for pins 2.7, 3.0-3.7 and 4.0-4.4
// assumes control bits come from port registers elsewhere, synchronous to clock_i
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_defs.svh"
module port_pin_function_mux (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // port configuration
  input wire logic port2_function_select_i,
  input wire logic port2_direction_i,
  input wire logic [7:0] port3_function_select_i,
  input wire logic [7:0] port3_direction_i,
  input wire logic [4:0] port4_function_select_i,
  input wire logic [4:0] port4_direction_i,
  input wire logic [7:0] analog_enable_low_i,
  input wire logic [7:0] analog_enable_high_i,
  input wire logic [2:0] port3_data_out_i,
  input wire logic [7:0] port3_gpio_out_i,
  input wire logic [4:0] port4_gpio_out_i,
  input wire logic port2_gpio_out_i,
  // op-amp routing
  input wire logic [1:0] opamp_adc_route_i,
  input wire logic [2:0] opamp_function_config_i,
  // peripheral sources
  input wire logic crystal_output_i,
  input wire logic [7:0] serial_out_i,
  input wire logic [7:0] serial_oe_i,
  input wire logic serial0_clock_active_i,
  input wire logic serial1_clock_active_i,
  input wire logic serial0_four_wire_i,
  input wire logic serial1_four_wire_i,
  input wire logic [4:0] timer_out_i,
  // pads
  input wire logic pad27_i,
  input wire logic [7:0] pad3_i,
  input wire logic [4:0] pad4_i,
  output logic pad27_o,
  output logic pad27_oe_o,
  output logic [7:0] pad3_o,
  output logic [7:0] pad3_oe_o,
  output logic [7:0] pad3_ie_o,
  output logic [4:0] pad4_o,
  output logic [4:0] pad4_oe_o,
  output logic [4:0] pad4_ie_o,
  // to peripherals
  output logic port2_in_o,
  output logic [7:0] serial_in_o,
  output logic [7:0] port3_in_o,
  output logic [4:0] timer_capture_o,
  output logic [4:0] port4_in_o,
  output logic serial0_three_wire_o,
  output logic serial1_three_wire_o,
  output logic [1:0] opamp_internal_o
);
  import pin_mux_pkg::*;

  // registered image of every pad and side-band output
  mux_state_t state_q;
  mux_state_t state_d;

  // analog disable per port 3 pin
  function automatic logic [7:0] p3_analog(input logic [7:0] ae);
    p3_analog = 8'h00;
    p3_analog[`P3_S1STE_S0CLK] = ae[`AE_LO_P30];
    p3_analog[`P3_ANALOG_6] = ae[`AE_LO_P36];
    p3_analog[`P3_ANALOG_7] = ae[`AE_LO_P37];
  endfunction

  // pad cut per port 4 pin: analog enable or opamp routed inside
  function automatic logic [4:0] p4_analog(input logic [7:0] ae, input logic oa);
    p4_analog = 5'h00;
    p4_analog[`P4_ANALOG_3] = ae[`AE_HI_P43] | oa;
    p4_analog[`P4_ANALOG_4] = ae[`AE_HI_P44] | oa;
  endfunction

  // opamp outputs reach adc channels twelve and thirteen inside
  function automatic logic opamp_inside(input logic [1:0] route, input logic [2:0] fcfg);
    opamp_inside = (route == `OA_ROUTE_INTERNAL) && (fcfg != `OA_FUNC_OFF);
  endfunction

  // decoded controls
  logic oa_int;
  logic [1:0] oa_pair;
  logic [7:0] p3_an;
  logic [4:0] p4_an;
  logic [7:0] p3_serial;
  logic s0_forced;
  logic s1_forced;

  // next pad drive values
  logic p27_out_mux;
  logic p27_oe_mux;
  logic [7:0] p3_out_mux;
  logic [7:0] p3_oe_mux;
  logic [4:0] p4_out_mux;
  logic [4:0] p4_oe_mux;

  // next input path values
  logic p27_in_mux;
  logic [7:0] p3_ie_mux;
  logic [7:0] p3_in_mux;
  logic [4:0] p4_ie_mux;
  logic [4:0] p4_in_mux;

  assign oa_int = opamp_inside(opamp_adc_route_i, opamp_function_config_i);
  assign oa_pair = {oa_int, oa_int};
  assign p3_an = p3_analog(analog_enable_low_i);
  assign p4_an = p4_analog(analog_enable_high_i, oa_int);

  // pin 2.7: crystal output while selected; it drives from reset on
  assign p27_out_mux = port2_function_select_i ? crystal_output_i : port2_gpio_out_i;
  assign p27_oe_mux = port2_function_select_i | port2_direction_i;
  assign p27_in_mux = pad27_i;

  // port 3 drive: pins 3.0-3.5 hand direction to the serial units
  generate
    for (genvar g = 0; g < `P3_PINS; g++) begin : g_port3_drive
      assign p3_serial[g] = port3_function_select_i[g] && (g <= `P3_SERIAL_LAST);
      assign p3_out_mux[g] = p3_serial[g] ? serial_out_i[g] : port3_gpio_out_i[g];
      assign p3_oe_mux[g] = (p3_serial[g] ? serial_oe_i[g] : port3_direction_i[g]) &
                            ~p3_an[g];
    end
  endgenerate

  // port 3 inputs: analog pins lose the schmitt input
  generate
    for (genvar g = 0; g < `P3_PINS; g++) begin : g_port3_input
      assign p3_ie_mux[g] = ~p3_an[g];
      assign p3_in_mux[g] = pad3_i[g] & ~p3_an[g];
    end
  endgenerate

  // port 4 drive: select hands the pin to the timer output
  generate
    for (genvar h = 0; h < `P4_PINS; h++) begin : g_port4_drive
      assign p4_out_mux[h] = port4_function_select_i[h] ? timer_out_i[h] : port4_gpio_out_i[h];
      assign p4_oe_mux[h] = port4_direction_i[h] & ~p4_an[h];
    end
  endgenerate

  // port 4 inputs: the pad also feeds the capture input whatever the direction
  generate
    for (genvar h = 0; h < `P4_PINS; h++) begin : g_port4_input
      assign p4_ie_mux[h] = ~p4_an[h];
      assign p4_in_mux[h] = pad4_i[h] & ~p4_an[h];
    end
  endgenerate

  // clock wins the shared pin; the other unit drops to 3-wire
  // serial0 clock on pin 3.0 beats serial1 slave enable
  assign s1_forced = port3_function_select_i[`P3_S1STE_S0CLK] &
                     serial0_clock_active_i & serial1_four_wire_i;
  // serial1 clock on pin 3.3 beats serial0 slave enable
  assign s0_forced = port3_function_select_i[`P3_S1CLK_S0STE] &
                     serial1_clock_active_i & serial0_four_wire_i;

  // all state moves as one register image
  always_comb begin
    state_d = state_q;
    state_d.p27_out = p27_out_mux;
    state_d.p27_oe = p27_oe_mux;
    state_d.p27_in = p27_in_mux;
    state_d.p3_out = p3_out_mux;
    state_d.p3_oe = p3_oe_mux;
    state_d.p3_ie = p3_ie_mux;
    state_d.p3_in = p3_in_mux;
    state_d.p4_out = p4_out_mux;
    state_d.p4_oe = p4_oe_mux;
    state_d.p4_ie = p4_ie_mux;
    state_d.p4_in = p4_in_mux;
    state_d.s0_three_wire = s0_forced;
    state_d.s1_three_wire = s1_forced;
    state_d.opamp_internal = oa_pair;
  end

  // crystal output drives pin 2.7 out of reset; other pins wait as inputs
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q.p27_out <= `PIN_LOW;
      state_q.p27_oe <= `P2_SEL_RESET;
      state_q.p27_in <= `PIN_LOW;
      state_q.p3_out <= `OUT_RESET_8;
      state_q.p3_oe <= `DIR_RESET_8;
      state_q.p3_ie <= `IE_RESET_8;
      state_q.p3_in <= `OUT_RESET_8;
      state_q.p4_out <= `OUT_RESET_5;
      state_q.p4_oe <= `DIR_RESET_5;
      state_q.p4_ie <= `IE_RESET_5;
      state_q.p4_in <= `OUT_RESET_5;
      state_q.s0_three_wire <= `PIN_LOW;
      state_q.s1_three_wire <= `PIN_LOW;
      state_q.opamp_internal <= `OA_INT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // pad drive, straight from the state register
  assign pad27_o = state_q.p27_out;
  assign pad27_oe_o = state_q.p27_oe;
  assign pad3_o = state_q.p3_out;
  assign pad3_oe_o = state_q.p3_oe;
  assign pad3_ie_o = state_q.p3_ie;
  assign pad4_o = state_q.p4_out;
  assign pad4_oe_o = state_q.p4_oe;
  assign pad4_ie_o = state_q.p4_ie;

  // inputs and status to the peripherals
  assign port2_in_o = state_q.p27_in;
  assign serial_in_o = state_q.p3_in;
  assign port3_in_o = state_q.p3_in;
  assign timer_capture_o = state_q.p4_in;
  assign port4_in_o = state_q.p4_in;
  assign serial0_three_wire_o = state_q.s0_three_wire;
  assign serial1_three_wire_o = state_q.s1_three_wire;
  assign opamp_internal_o = state_q.opamp_internal;
endmodule // port_pin_function_mux
`default_nettype wire

// ---- tb/periph_model.sv ----
// far side: crystal output and timer outputs
// assumes the mux samples them on the rising edge
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input wire logic clock_i,
  output logic crystal_output_o,
  output logic [4:0] timer_out_o
);
  initial {crystal_output_o, timer_out_o} = 6'h00;
  always @(posedge clock_i) begin
    crystal_output_o <= !crystal_output_o;
    timer_out_o <= timer_out_o + 5'h0b;
  end
endmodule // periph_model
`default_nettype wire

// ---- tb/pin_mux_asserts.sv ----
// concurrent checks on the pin function mux ports
// assumes one clock; outputs lag inputs by one cycle
`timescale 1ns/1ns
`default_nettype none
module pin_mux_asserts (
  input wire logic clock_i, reset_i, port2_function_select_i, crystal_output_i, pad27_o,
  input wire logic serial0_clock_active_i, serial1_clock_active_i, serial0_four_wire_i, serial1_four_wire_i,
  input wire logic serial0_three_wire_o, serial1_three_wire_o,
  input wire logic [7:0] port3_function_select_i, analog_enable_low_i, analog_enable_high_i, pad3_oe_o, pad3_ie_o,
  input wire logic [4:0] port4_function_select_i, port4_direction_i, timer_out_i, pad4_o, pad4_oe_o, pad4_ie_o,
  input wire logic [1:0] opamp_adc_route_i, opamp_internal_o,
  input wire logic [2:0] opamp_function_config_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_xo; $past(!reset_i & port2_function_select_i) |-> pad27_o == $past(crystal_output_i); endproperty
  a_xo: assert property (p_xo) else $error("crystal not on pin");
  property p_s1; $past(!reset_i & port3_function_select_i[0] & serial0_clock_active_i & serial1_four_wire_i
    & !analog_enable_low_i[5]) |-> serial1_three_wire_o; endproperty
  a_s1: assert property (p_s1) else $error("serial1 not three wire");
  property p_s0; $past(!reset_i & port3_function_select_i[3] & serial1_clock_active_i & serial0_four_wire_i)
    |-> serial0_three_wire_o; endproperty
  a_s0: assert property (p_s0) else $error("serial0 not three wire");
  property p_a0; $past(!reset_i & analog_enable_low_i[5]) |-> !pad3_oe_o[0] && !pad3_ie_o[0]; endproperty
  a_a0: assert property (p_a0) else $error("pin 3.0 not detached");
  property p_a7; $past(!reset_i & analog_enable_low_i[7]) |-> {pad3_oe_o[7], pad3_ie_o[7]} == 2'h0; endproperty
  a_a7: assert property (p_a7) else $error("pin 3.7 not detached");
  property p_a1; $past(!reset_i & analog_enable_high_i[4]) |-> !pad4_oe_o[3] && !pad4_ie_o[3]; endproperty
  a_a1: assert property (p_a1) else $error("pin 4.3 not detached");
  property p_oa; $past(!reset_i && opamp_adc_route_i == 2'h3 && opamp_function_config_i != 3'h0)
    |-> opamp_internal_o == 2'h3 && pad4_oe_o[4:3] == 2'h0; endproperty
  a_oa: assert property (p_oa) else $error("opamp route wrong");
  property p_tm; $past(!reset_i & port4_function_select_i[0] & port4_direction_i[0])
    |-> pad4_oe_o[0] && pad4_o[0] == $past(timer_out_i[0]); endproperty
  a_tm: assert property (p_tm) else $error("timer not on pin");
endmodule // pin_mux_asserts
bind port_pin_function_mux pin_mux_asserts chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench: random pin settings, queued expectations
// assumes the mux answers one clock after sampling
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock_i, reset_i, port2_function_select_i, port2_direction_i, port2_gpio_out_i, crystal_output_i, pad27_i;
  logic serial0_clock_active_i, serial1_clock_active_i, serial0_four_wire_i, serial1_four_wire_i, oa;
  logic pad27_o, pad27_oe_o, port2_in_o, serial0_three_wire_o, serial1_three_wire_o;
  logic [7:0] port3_function_select_i, port3_direction_i, analog_enable_low_i, analog_enable_high_i, serial_oe_i;
  logic [7:0] port3_gpio_out_i, serial_out_i, pad3_i, pad3_o, pad3_oe_o, pad3_ie_o, serial_in_o, port3_in_o, m, e;
  logic [4:0] port4_function_select_i, port4_direction_i, port4_gpio_out_i, timer_out_i, pad4_i, pad4_o;
  logic [4:0] pad4_oe_o, pad4_ie_o, timer_capture_o, port4_in_o;
  logic [1:0] opamp_adc_route_i, opamp_internal_o;
  logic [2:0] opamp_function_config_i, port3_data_out_i;
  logic [31:0] s;
  logic [127:0] r;
  logic [15:0] x;
  logic [15:0] q[$];
  logic [7:0] an3, p3s;
  logic [4:0] an4;
  logic [52:0] y;
  logic [52:0] w[$];
  int failures, cmp_count;
  port_pin_function_mux DUT (.*);
  periph_model far (.clock_i(clock_i), .crystal_output_o(crystal_output_i), .timer_out_o(timer_out_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic roll;
    repeat (4) begin
      s = xs(s);
      r = {r[95:0], s};
    end
    {port3_function_select_i, port3_direction_i, analog_enable_low_i, analog_enable_high_i, port3_gpio_out_i,
     serial_out_i, serial_oe_i, pad3_i, port4_function_select_i, port4_direction_i, port4_gpio_out_i, pad4_i,
     opamp_adc_route_i, opamp_function_config_i, port2_function_select_i, port2_direction_i, port2_gpio_out_i,
     pad27_i, serial0_clock_active_i, serial1_clock_active_i, serial0_four_wire_i, serial1_four_wire_i} = r[96:0];
  endtask
  task automatic cmp(input logic [13:0] got, input logic [13:0] want);
    cmp_count++;
    if (got !== want) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_wide(input logic [52:0] got, input logic [52:0] want);
    cmp_count++;
    if (got !== want) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    s = 32'h00011f78;
    reset_i = 1'b1;
    port3_data_out_i = 3'h0;
    roll();
    port2_function_select_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #1 cmp({pad27_oe_o, pad3_oe_o, pad4_oe_o}, 14'h2000);
    cmp_wide({40'h0, pad3_ie_o, pad4_ie_o}, {40'h0, 8'hff, 5'h1f});
    repeat (500) begin
      @(negedge clock_i);
      reset_i = 1'b0;
      roll();
      oa = opamp_adc_route_i == 2'h3 && opamp_function_config_i != 3'h0;
      m = {port4_direction_i[0], 3'h7, port3_function_select_i[3] & serial1_clock_active_i & serial0_four_wire_i,
           port3_function_select_i[0] & serial0_clock_active_i & serial1_four_wire_i & !analog_enable_low_i[5],
           port2_function_select_i, 1'b1};
      e = {port4_function_select_i[0] & port4_direction_i[0] ? timer_out_i[0] : port4_gpio_out_i[0], oa,
           !(analog_enable_high_i[4] | oa) & port4_direction_i[3],
           !analog_enable_low_i[5] & (port3_function_select_i[0] ? serial_oe_i[0] : port3_direction_i[0]),
           2'h3, crystal_output_i, port2_function_select_i | port2_direction_i};
      q.push_back({m, e});
      an3 = {analog_enable_low_i[7:6], 5'h00, analog_enable_low_i[5]};
      an4 = {analog_enable_high_i[5:4] | {2{oa}}, 3'h0};
      p3s = port3_function_select_i & 8'h3f;
      w.push_back({(p3s & serial_out_i) | (~p3s & port3_gpio_out_i), ~an3, {2{pad3_i & ~an3}},
                   ~an4, {2{pad4_i & ~an4}}, pad27_i, port4_direction_i & ~an4});
    end
    @(posedge clock_i);
    #2 final_report();
  end
  always @(posedge clock_i) begin
    #1;
    if (q.size() > 0) begin
      x = q.pop_front();
      cmp({6'h00, x[15:8] & {pad4_o[0], opamp_internal_o[0], pad4_oe_o[3], pad3_oe_o[0], serial0_three_wire_o,
          serial1_three_wire_o, pad27_o, pad27_oe_o}}, {6'h00, x[15:8] & x[7:0]});
    end
    if (w.size() > 0) begin
      y = w.pop_front();
      cmp_wide({pad3_o, pad3_ie_o, port3_in_o, serial_in_o, pad4_ie_o, port4_in_o, timer_capture_o,
                port2_in_o, pad4_oe_o}, y);
    end
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
